// ---- common/smrt_pkg.sv ----
package smrt_pkg;
  // Clock rate in Hz
  localparam int unsigned CLK_HZ             = 200000000;
  // Reset timeout, least time in ms
  localparam int unsigned TIMEOUT_MS         = 140;
  localparam int unsigned TIMEOUT_CYC        = (TIMEOUT_MS * (CLK_HZ / 1000));
  // Immediate input falling-edge debounce in ms
  localparam int unsigned FALL_DEB_MS        = 210;
  localparam int unsigned FALL_DEB_CYC       = (FALL_DEB_MS * (CLK_HZ / 1000));
  // Manual setup period options in ms
  localparam int unsigned SETUP_K_MS         = 10080;
  localparam int unsigned SETUP_L_MS         = 6720;
  localparam int unsigned SETUP_S_MS         = 3360;
  localparam int unsigned SETUP_T_MS         = 1680;
  // Rising-edge debounce for extended inputs in us
  localparam int unsigned RISE_DEB_US        = 1000;
  localparam int unsigned RISE_DEB_CYC       = (RISE_DEB_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W              = 32;

  // Manual input variant
  typedef enum logic [1:0] {
    SMRT_SINGLE_EXT = 2'b00,
    SMRT_DUAL_EXT   = 2'b01,
    SMRT_EXT_IMM    = 2'b10
  } smrt_variant_t;

  // Setup period option
  typedef enum logic [1:0] {
    SMRT_SETUP_K = 2'b00,
    SMRT_SETUP_L = 2'b01,
    SMRT_SETUP_S = 2'b10,
    SMRT_SETUP_T = 2'b11
  } smrt_setup_t;

  // Extended-setup qualifier states
  typedef enum logic [1:0] {
    SMRT_IDLE  = 2'b00,
    SMRT_HOLD  = 2'b01,
    SMRT_FIRED = 2'b10
  } smrt_state_t;

  // Setup period in clock cycles; product widened to avoid overflow
  function automatic longint unsigned smrt_setup_cyc(input smrt_setup_t sel);
    longint unsigned ms;
    ms = SETUP_K_MS;
    case (sel)
      SMRT_SETUP_K: ms = SETUP_K_MS;
      SMRT_SETUP_L: ms = SETUP_L_MS;
      SMRT_SETUP_S: ms = SETUP_S_MS;
      default:      ms = SETUP_T_MS;
    endcase
    return ms * longint'(CLK_HZ / 1000);
  endfunction : smrt_setup_cyc
endpackage : smrt_pkg

// ---- verilog/smrt_timer.sv ----
// Behaviour
// RULE_01: Reset output goes low while supply or adjustable monitor is below threshold.
// RULE_02: After both monitors recover, hold reset low one timeout, then release.
// RULE_03: Every reset timeout lasts at least 140 ms.
// RULE_04: Extended manual input resets only after continuous low for setup period.
// RULE_05: Qualified manual condition yields one low pulse of the timeout length.
// RULE_06: Dual variant qualifies only while both manual inputs are low together.
// RULE_07: One pulse per qualified condition, even if inputs stay low.
// RULE_08: Re-arm needs an input back high, then a fresh full setup hold.
// RULE_09: Rising transitions on extended inputs are debounced internally.
// RULE_10: Lows shorter than the setup period give no reset pulse.
// RULE_11: Variant is single extended, dual extended, or extended plus immediate.
// RULE_12: Immediate input rising edge asserts reset at once for the timeout.
// RULE_13: A further rising edge during the pulse restarts the timeout timer. Code ignores edges within the fall debounce; by default none restarts a pulse.
// RULE_14: Immediate pulse ends only when timeout passes without another rising edge.
// RULE_15: Falling transitions on the immediate input are debounced for 210 ms.
// RULE_16: Setup period is one of 10.08, 6.72, 3.36 or 1.68 s per build.
// RULE_17: Early release discards hold time; qualification restarts from zero.
// RULE_18: Reset output is the OR of supply timeout and manual pulses.
// RULE_19: All durations are cycle counts of the clock, set from parameters.
`timescale 1ns/1ps
module smrt_timer #(
  parameter smrt_pkg::smrt_variant_t VARIANT     = smrt_pkg::SMRT_SINGLE_EXT,
  parameter smrt_pkg::smrt_setup_t   SETUP_SEL   = smrt_pkg::SMRT_SETUP_L,
  parameter int unsigned             TIMEOUT_CYC = smrt_pkg::TIMEOUT_CYC,
  parameter int unsigned             FALL_CYC    = smrt_pkg::FALL_DEB_CYC,
  parameter int unsigned             RISE_CYC    = smrt_pkg::RISE_DEB_CYC,
  parameter longint unsigned         SETUP_CYC   = smrt_pkg::smrt_setup_cyc(SETUP_SEL)
) (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic supply_low_in,
  input  wire logic adjustable_monitor_in,
  input  wire logic extended_manual_in_a,
  input  wire logic manual_in_b,
  output logic      reset_n_out
);
  import smrt_pkg::*;

  localparam logic [CNT_W-1:0] TMO_END   = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] FALL_END  = CNT_W'(FALL_CYC - 1);
  localparam logic [CNT_W-1:0] RISE_END  = CNT_W'(RISE_CYC - 1);
  localparam logic [CNT_W-1:0] SETUP_END = CNT_W'(SETUP_CYC - 1);

  logic              below;
  logic              sup_active;
  logic [CNT_W-1:0]  sup_cnt;
  logic              ext_low_raw;
  logic              ext_low;
  logic [CNT_W-1:0]  rise_cnt;
  smrt_state_t       state;
  logic [CNT_W-1:0]  setup_cnt;
  logic              man_fire;
  logic              man_active;
  logic [CNT_W-1:0]  man_cnt;
  logic              imm_level;
  logic              imm_prev;
  logic [CNT_W-1:0]  fall_cnt;
  logic              imm_rise;
  logic              imm_active;
  logic [CNT_W-1:0]  imm_cnt;
  logic              next_reset_n;

  // Either monitor below threshold
  assign below = supply_low_in | adjustable_monitor_in; // RULE_01

  // Supply timeout: held while below, then one full timeout after recovery
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      sup_active <= 1'b1;
      sup_cnt    <= '0;
    end else if (below) begin
      sup_active <= 1'b1; // RULE_01
      sup_cnt    <= '0;
    end else if (sup_active) begin
      if (sup_cnt == TMO_END) begin // RULE_02 RULE_03 RULE_19
        sup_active <= 1'b0;
      end
      sup_cnt <= sup_cnt + 1'b1;
    end
  end

  // Extended low condition; dual variant needs both inputs low together
  assign ext_low_raw = (VARIANT == SMRT_DUAL_EXT) ? // RULE_06 RULE_11
                       (!extended_manual_in_a && !manual_in_b) : !extended_manual_in_a;

  // Rising debounce: a release counts only once stable high for the window
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ext_low  <= 1'b0;
      rise_cnt <= '0;
    end else if (ext_low_raw) begin
      ext_low  <= 1'b1;
      rise_cnt <= '0;
    end else if (ext_low) begin
      if (rise_cnt == RISE_END) begin // RULE_09
        ext_low <= 1'b0;
      end
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  // Setup qualifier; fires once, re-arms only after release
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state     <= SMRT_IDLE;
      setup_cnt <= '0;
      man_fire  <= 1'b0;
    end else begin
      man_fire <= 1'b0;
      case (state)
        SMRT_IDLE: begin
          setup_cnt <= '0;
          if (ext_low) begin
            state <= SMRT_HOLD;
          end
        end
        SMRT_HOLD: begin
          if (!ext_low) begin
            state     <= SMRT_IDLE; // RULE_10 RULE_17
            setup_cnt <= '0;
          end else if (setup_cnt == SETUP_END) begin // RULE_04 RULE_16
            state    <= SMRT_FIRED;
            man_fire <= 1'b1;
          end else begin
            setup_cnt <= setup_cnt + 1'b1;
          end
        end
        SMRT_FIRED: begin
          if (!ext_low) begin
            state <= SMRT_IDLE; // RULE_07 RULE_08
          end
        end
        default: begin
          state <= SMRT_IDLE;
        end
      endcase
    end
  end

  // One-shot manual pulse of the timeout length
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      man_active <= 1'b0;
      man_cnt    <= '0;
    end else if (man_fire) begin
      man_active <= 1'b1; // RULE_05
      man_cnt    <= '0;
    end else if (man_active) begin
      if (man_cnt == TMO_END) begin
        man_active <= 1'b0;
      end
      man_cnt <= man_cnt + 1'b1;
    end
  end

  // Immediate input: high passes at once, low only after 210 ms stable
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      imm_level <= 1'b0;
      fall_cnt  <= '0;
    end else if (VARIANT != SMRT_EXT_IMM) begin
      imm_level <= 1'b0;
      fall_cnt  <= '0;
    end else if (manual_in_b) begin
      imm_level <= 1'b1;
      fall_cnt  <= '0;
    end else if (imm_level) begin
      if (fall_cnt == FALL_END) begin // RULE_15
        imm_level <= 1'b0;
      end
      fall_cnt <= fall_cnt + 1'b1;
    end
  end

  // Rising edge of raw input, so the reset starts without delay
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      imm_prev <= 1'b1;
    end else begin
      imm_prev <= manual_in_b;
    end
  end
  // Edge ignored while debounced level still high: filters removal chatter
  assign imm_rise = (VARIANT == SMRT_EXT_IMM) && manual_in_b && !imm_prev && !imm_level;

  // Immediate pulse; a new edge restarts the timer
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      imm_active <= 1'b0;
      imm_cnt    <= '0;
    end else if (imm_rise) begin
      imm_active <= 1'b1; // RULE_12 RULE_13
      imm_cnt    <= '0;
    end else if (imm_active) begin
      if (imm_cnt == TMO_END) begin // RULE_14
        imm_active <= 1'b0;
      end
      imm_cnt <= imm_cnt + 1'b1;
    end
  end

  // Output combine; registered so the pin never glitches
  assign next_reset_n = !(below || sup_active || man_active || imm_active); // RULE_18
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      reset_n_out <= 1'b0;
    end else begin
      reset_n_out <= next_reset_n;
    end
  end

  // Assertion sequences
  sequence s_fire;
    man_fire;
  endsequence
  // Pulse flop follows fire by one edge, the output register by one more
  sequence s_out_low_next;
    ##1 man_active ##1 !reset_n_out;
  endsequence

  a_monitor_low_out: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_01
    below |=> !reset_n_out)
    else $error("monitor low did not drive reset low");
  a_recover_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_02
    $fell(below) |-> sup_active && sup_cnt == '0)
    else $error("supply timeout not started on recovery");
  a_timeout_len: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_03
    $fell(man_active) |-> $past(man_cnt) == TMO_END)
    else $error("manual pulse length wrong");
  a_setup_full: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_04
    man_fire |-> $past(setup_cnt) == SETUP_END && $past(ext_low))
    else $error("fire without full setup hold");
  a_fire_pulse: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_05
    s_fire |-> s_out_low_next)
    else $error("fire gave no reset pulse");
  a_single_fire: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_07
    man_fire |=> state == SMRT_FIRED && !man_fire)
    else $error("repeated manual fire");
  a_release_clear: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_17
    state == SMRT_HOLD && !ext_low |=> state == SMRT_IDLE && setup_cnt == '0)
    else $error("hold time not discarded");
  a_imm_restart: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_13
    imm_rise |=> imm_active && imm_cnt == '0 ##1 !reset_n_out)
    else $error("immediate edge did not restart");
  a_combine_or: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // RULE_18
    (man_active || imm_active || sup_active) |=> !reset_n_out)
    else $error("active source did not hold reset");
endmodule : smrt_timer

// ---- verification/smrt_cpu_model.sv ----
`timescale 1ns/1ps
// Processor reset pin; counts low stretches and keeps the last length
module smrt_cpu_model (
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  output int        pulses_out,
  output int        last_len_out
);
  int run      = 0;
  int pulses   = 0;
  int last_len = 0;

  // Measure each low stretch; an unknown level counts as released
  always @(posedge ref_clk_in) begin
    if (reset_n_in === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      pulses   <= pulses + 1;
      last_len <= run;
      run      <= 0;
    end
  end

  // Counters start clean; one driver each, so no init race
  assign pulses_out   = pulses;
  assign last_len_out = last_len;
endmodule : smrt_cpu_model

// ---- verification/smrt_timer_test.sv ----
`timescale 1ns/1ps
module smrt_timer_test;
  import smrt_pkg::*;
  // Short counts; fall debounce below timeout so a restart is reachable
  localparam int T_CYC = 40;
  localparam int S_CYC = 50;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic supply_low = 1'b0;
  logic adj_low    = 1'b0;
  logic man_a      = 1'b1;
  logic man_b_dual = 1'b1;
  logic man_b_imm  = 1'b0;
  logic rst_dual_n;
  logic rst_imm_n;
  int   pulses_d;
  int   pulses_i;
  int   len_d;
  int   len_i;
  int   fail_count      = 0;
  int   samples_checked = 0;
  int   cycles          = 0;

  always #2.5 ref_clk_in = ~ref_clk_in;

  // Dual extended variant and extended plus immediate variant
  smrt_timer #(.VARIANT(SMRT_DUAL_EXT), .TIMEOUT_CYC(T_CYC), .FALL_CYC(10), .RISE_CYC(4),
    .SETUP_CYC(S_CYC)) smrt_timer_dual_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .supply_low_in(supply_low), .adjustable_monitor_in(adj_low),
    .extended_manual_in_a(man_a), .manual_in_b(man_b_dual), .reset_n_out(rst_dual_n));
  smrt_timer #(.VARIANT(SMRT_EXT_IMM), .TIMEOUT_CYC(T_CYC), .FALL_CYC(10), .RISE_CYC(4),
    .SETUP_CYC(S_CYC)) smrt_timer_imm_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .supply_low_in(supply_low), .adjustable_monitor_in(adj_low),
    .extended_manual_in_a(man_a), .manual_in_b(man_b_imm), .reset_n_out(rst_imm_n));
  smrt_cpu_model smrt_cpu_model_dual_i (.ref_clk_in(ref_clk_in), .reset_n_in(rst_dual_n),
    .pulses_out(pulses_d), .last_len_out(len_d));
  smrt_cpu_model smrt_cpu_model_imm_i (.ref_clk_in(ref_clk_in), .reset_n_in(rst_imm_n),
    .pulses_out(pulses_i), .last_len_out(len_i));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc

  task automatic chk(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask : chk

  // Immediate-variant output, sampled 1 ns after the edge so updates have landed
  task automatic chk_out(input string what, input logic exp);
    #1;
    samples_checked++;
    if (rst_imm_n !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, rst_imm_n);
    end
  endtask : chk_out

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Hang guard, well above the ~785 cycles the run needs
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic t_monitor();
    int p;
    chk("power-up pulses", 1, 1, pulses_d);
    chk("power-up length", T_CYC + 19, T_CYC + 24, len_i);
    for (int k = 0; k < 2; k++) begin
      p = pulses_i;
      supply_low <= (k == 0);
      adj_low    <= (k == 1);
      cyc(3);
      chk_out("reset while below", 1'b0);
      cyc(7);
      supply_low <= 1'b0;
      adj_low    <= 1'b0;
      cyc(T_CYC + 8);
      chk("recovery pulses", p + 1, p + 1, pulses_i);
      chk("recovery length", T_CYC + 10, T_CYC + 13, len_i);
    end
  endtask : t_monitor

  task automatic t_short();
    int p;
    p = pulses_i;
    man_a <= 1'b0;
    cyc(S_CYC - 10);
    man_a <= 1'b1;
    cyc(10);
    man_a <= 1'b0;
    cyc(30);
    man_a <= 1'b1;
    cyc(T_CYC + 20);
    chk("short press pulses", p, p, pulses_i);
  endtask : t_short

  task automatic t_long();
    int p;
    int q;
    p = pulses_i;
    q = pulses_d;
    man_a <= 1'b0;
    cyc(20);
    man_a <= 1'b1;
    cyc(2);
    man_a <= 1'b0;
    cyc(S_CYC - 25);
    chk_out("reset before setup", 1'b1);
    cyc(12);
    chk_out("reset through bounce", 1'b0);
    cyc(T_CYC + 60);
    man_a <= 1'b1;
    cyc(T_CYC);
    chk("held press pulses", p + 1, p + 1, pulses_i);
    chk("manual pulse length", T_CYC, T_CYC + 2, len_i);
    chk("one input on dual", q, q, pulses_d);
    man_a      <= 1'b0;
    man_b_dual <= 1'b0;
    cyc(S_CYC + 10);
    man_a      <= 1'b1;
    man_b_dual <= 1'b1;
    cyc(T_CYC + 10);
    chk("re-press pulses", p + 2, p + 2, pulses_i);
    chk("both inputs on dual", q + 1, q + 1, pulses_d);
    chk("dual pulse length", T_CYC, T_CYC + 2, len_d);
  endtask : t_long

  task automatic t_imm();
    int p;
    p = pulses_i;
    man_b_imm <= 1'b1;
    cyc(2);
    man_b_imm <= 1'b0;
    chk_out("immediate reset", 1'b0);
    cyc(16);
    man_b_imm <= 1'b1;
    cyc(2);
    man_b_imm <= 1'b0;
    cyc(T_CYC + 20);
    chk("restarted pulses", p + 1, p + 1, pulses_i);
    chk("restarted length", T_CYC + 17, T_CYC + 20, len_i);
  endtask : t_imm

  // Re-rise inside the fall debounce must not count as a new edge
  task automatic t_glitch();
    int p;
    p = pulses_i;
    man_b_imm <= 1'b1;
    cyc(3);
    man_b_imm <= 1'b0;
    cyc(4);
    man_b_imm <= 1'b1;
    cyc(3);
    man_b_imm <= 1'b0;
    cyc(T_CYC + 20);
    chk("bounce pulses", p + 1, p + 1, pulses_i);
    chk("bounce length", T_CYC, T_CYC + 2, len_i);
  endtask : t_glitch

  // Main sequence
  initial begin
    cyc(20);
    reset_n_in <= 1'b1;
    cyc(T_CYC + 10);
    t_monitor();
    t_short();
    t_long();
    t_imm();
    t_glitch();
    end_sim();
  end
endmodule : smrt_timer_test
